// ---- rtl/sdc_pkg.sv ----
package sdc_pkg;

  // Field widths of the divider configuration.
  localparam int FB_W    = 9;
  localparam int OD_W    = 3;
  localparam int DS_W    = 2;
  localparam int FRAME_W = DS_W + OD_W + FB_W;
  localparam int CNT_W   = 9;

  // Field positions inside the serial frame, diagnostic bits first in time.
  localparam int FRAME_FB_LSB = 0;
  localparam int FRAME_OD_LSB = FB_W;
  localparam int FRAME_DS_LSB = FB_W + OD_W;

  // Register port geometry and offsets.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] STATUS_OFS  = 8'h00;
  localparam logic [ADDR_W-1:0] CONTROL_OFS = 8'h04;

  // Status and control register field positions.
  localparam int ST_FB_LSB   = 0;
  localparam int ST_OD_LSB   = 9;
  localparam int ST_DS_LSB   = 12;
  localparam int ST_PAR_BIT  = 14;
  localparam int ST_RST_BIT  = 15;
  localparam int ST_BYP_BIT  = 16;
  localparam int ST_REF_BIT  = 17;
  localparam int CTL_RST_BIT = 0;

  // Reset values of the loaded configuration.
  localparam logic [FB_W-1:0]    FB_RESET    = 9'h000;
  localparam logic [OD_W-1:0]    OD_RESET    = 3'h0;
  localparam logic [DS_W-1:0]    DS_RESET    = 2'h0;
  localparam logic [FRAME_W-1:0] FRAME_RESET = 14'h0000;

  // Diagnostic output selections.
  localparam logic [DS_W-1:0] DIAG_LOW    = 2'h0;
  localparam logic [DS_W-1:0] DIAG_SDATA  = 2'h1;
  localparam logic [DS_W-1:0] DIAG_FB     = 2'h2;
  localparam logic [DS_W-1:0] DIAG_SYNTH  = 2'h3;

  // Loaded divider configuration.
  typedef struct packed {
    logic [DS_W-1:0] diag_sel;
    logic [OD_W-1:0] out_div;
    logic [FB_W-1:0] feedback_div;
  } sdc_cfg_t;

  // Configuration pins as they arrive from the board.
  typedef struct packed {
    logic            master_reset;
    logic            parallel_latch_n;
    logic [FB_W-1:0] feedback_div;
    logic [OD_W-1:0] out_div;
    logic            serial_clock;
    logic            serial_data;
    logic            serial_load;
    logic            ref_source_select;
    logic            pll_bypass_select;
    logic            crystal_ref;
    logic            alt_ref;
  } sdc_pins_t;

  localparam int PINS_W = $bits(sdc_pins_t);

endpackage

// ---- rtl/sdc_config_port.sv ----
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps

// How it works
// [R1] Master reset high clears dividers; true outputs low, complementary outputs high.
// [R2] Master reset low lets dividers run and enables the synthesizer outputs.
// [R3] Master reset never alters the loaded feedback, output or diagnostic values.
// [R4] Master reset overrides every other configuration input and forces the diagnostic output low.
// [R5] Serial data is sampled into the shift register on each rising shift clock.
// [R6] Reference select high picks the crystal, low picks the alternate reference.
// [R7] A select input chooses PLL operation or bypass operation.
// [R8] The parallel latch input governs loading of feedback and output divider pins.
// [R9] Reset low and latch low pass divider pins straight to the dividers.
// [R10] In parallel mode the diagnostic output is low whatever the select bits.
// [R11] Latch rising with transfer strobe low captures pins until latch falls or serial event.
// [R12] Latch high, strobe low: each rising shift clock shifts one data bit in.
// [R13] Latch high, shift clock low: rising strobe moves shift register into dividers.
// [R14] Latch high: falling strobe freezes divider values against later serial activity.
// [R15] Latch high, strobe low: pin or serial changes leave loaded dividers alone.
// [R16] Latch high, strobe high: each rising shift clock feeds data through to dividers.
// [R17] Select 00 low, 01 serial input, 10 feedback divider, 11 synthesizer copy.
// [R18] Feedback divide value is plain binary, weight 256 down to 1.
// [R19] Output codes 000-011 divide 2,4,8,16; codes 100-111 divide 1,2,4,8; the divider here makes code 100 divide by 2.
// [R20] Controller keeps feedback divide between 100 and 350 at 16 MHz reference.
// [R21] Frame: two select bits, three output bits, nine feedback bits, MSB first.
// [R22] Controller holds latch high, shift clock low while pulsing the strobe.
module sdc_config_port
(
  input  wire logic                       clk_sys_in,
  input  wire logic                       rst_b_in,
  input  wire sdc_pkg::sdc_pins_t         pins_in,
  input  wire logic [sdc_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [sdc_pkg::DATA_W-1:0] wr_data_in,
  input  wire logic                       wr_en_in,
  input  wire logic                       rd_en_in,
  output logic      [sdc_pkg::DATA_W-1:0] rd_data_out,
  output logic                            synth_out_a_out,
  output logic                            synth_out_a_comp_out,
  output logic                            synth_out_b_out,
  output logic                            synth_out_b_comp_out,
  output logic                            diag_out
);
  import sdc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Rising edge between the previous and the current synchronised sample.
  function automatic logic rise(input logic prev, input logic cur);
    rise = cur & ~prev;
  endfunction

  // Falling edge between the previous and the current synchronised sample.
  function automatic logic fall(input logic prev, input logic cur);
    fall = prev & ~cur;
  endfunction

  // Output divide ratio for a three-bit code; the top bit halves the ratio.
  function automatic logic [CNT_W-1:0] out_ratio(input logic [OD_W-1:0] code);
    logic [CNT_W-1:0] base;
    base = CNT_W'(9'h002) << code[1:0];
    if (code[2])
    begin
      out_ratio = base >> 1;
    end
    else
    begin
      out_ratio = base;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Reset release and state record.

  logic [1:0] rst_sync_reg;
  logic       rst_b;

  typedef struct packed {
    logic [PINS_W-1:0]  pins_meta;
    sdc_pins_t          pins_sync;
    sdc_pins_t          pins_prev;
    sdc_cfg_t           cfg;
    logic [FRAME_W-1:0] shift;
    logic               soft_reset;
    logic [CNT_W-1:0]   fb_cnt;
    logic               fb_out;
    logic [CNT_W-1:0]   od_cnt;
    logic               synth;
    logic               out_true;
    logic               out_comp;
    logic               diag;
    logic [DATA_W-1:0]  rd_data;
  } sdc_state_t;

  sdc_state_t state_reg;
  sdc_state_t state_next;

  // The reset is released through two flops so that every state flop leaves reset together.
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rst_sync_reg <= 2'h0;
    end
    else
    begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_b = rst_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // Pins come from another timing domain; only the second stage and its delayed copy are
  // looked at, so every edge below is detected one to two cycles after it occurs.
  always_comb
  begin
    logic              hold_reset;
    logic              pl_n;
    logic              sclk_rise;
    logic              sload_high;
    logic              ref_level;
    logic              ref_prev;
    logic              tick;
    logic [CNT_W-1:0]  fb_limit;
    logic [CNT_W-1:0]  od_half;
    logic [FRAME_W-1:0] shifted;
    hold_reset = 1'b0;
    pl_n       = 1'b0;
    sclk_rise  = 1'b0;
    sload_high = 1'b0;
    ref_level  = 1'b0;
    ref_prev   = 1'b0;
    tick       = 1'b0;
    fb_limit   = '0;
    od_half    = '0;
    shifted    = '0;

    state_next           = state_reg;
    state_next.pins_meta = pins_in;
    state_next.pins_sync = sdc_pins_t'(state_reg.pins_meta);
    state_next.pins_prev = state_reg.pins_sync;

    hold_reset = state_reg.pins_sync.master_reset | state_reg.soft_reset;
    pl_n       = state_reg.pins_sync.parallel_latch_n;
    sclk_rise  = rise(state_reg.pins_prev.serial_clock, state_reg.pins_sync.serial_clock);
    sload_high = state_reg.pins_sync.serial_load;
    shifted    = {state_reg.shift[FRAME_W-2:0], state_reg.pins_sync.serial_data};

    // Loading of the divider configuration; reset freezes it rather than clearing it.
    if (hold_reset)
    begin
      state_next.cfg   = state_reg.cfg;                        // see [R3] see [R4]
      state_next.shift = state_reg.shift;
    end
    else if (!pl_n)
    begin
      state_next.cfg.feedback_div = state_reg.pins_sync.feedback_div;  // see [R8] see [R9]
      state_next.cfg.out_div      = state_reg.pins_sync.out_div;
    end
    else if (rise(state_reg.pins_prev.parallel_latch_n, pl_n) && !sload_high)
    begin
      // The pins seen at the latch edge are captured and then held.
      state_next.cfg.feedback_div = state_reg.pins_sync.feedback_div;  // see [R11]
      state_next.cfg.out_div      = state_reg.pins_sync.out_div;
    end
    else
    begin
      if (sclk_rise)
      begin
        state_next.shift = shifted;                            // see [R5] see [R12] see [R21]
      end
      if (sload_high && sclk_rise)
      begin
        state_next.cfg = sdc_cfg_t'(shifted);                  // see [R16]
      end
      else if (rise(state_reg.pins_prev.serial_load, sload_high) &&
               !state_reg.pins_sync.serial_clock)
      begin
        state_next.cfg = sdc_cfg_t'(state_reg.shift);          // see [R13]
      end
      // A falling strobe or a low strobe leaves cfg untouched.  see [R14] see [R15]
    end

    // Stand-in for the oscillator: the system clock in PLL mode, reference edges in bypass.
    ref_level = state_reg.pins_sync.ref_source_select ?
                state_reg.pins_sync.crystal_ref : state_reg.pins_sync.alt_ref;  // see [R6]
    ref_prev  = state_reg.pins_prev.ref_source_select ?
                state_reg.pins_prev.crystal_ref : state_reg.pins_prev.alt_ref;
    tick      = state_reg.pins_sync.pll_bypass_select ? 1'b1 : rise(ref_prev, ref_level);  // see [R7]

    // A zero value would wrap the compare to 511, so it is treated as a value of one.
    fb_limit = (state_reg.cfg.feedback_div == '0) ? CNT_W'(9'h001) :
               state_reg.cfg.feedback_div;                     // see [R18]
    od_half  = out_ratio(state_reg.cfg.out_div) >> 1;          // see [R19]
    if (od_half == '0)
    begin
      od_half = CNT_W'(9'h001);
    end

    // Dividers are held cleared under reset and run freely otherwise.
    if (hold_reset)
    begin
      state_next.fb_cnt = '0;                                  // see [R1]
      state_next.fb_out = 1'b0;
      state_next.od_cnt = '0;
      state_next.synth  = 1'b0;
    end
    else if (tick)
    begin
      if (state_reg.fb_cnt >= fb_limit - CNT_W'(9'h001))       // see [R2]
      begin
        state_next.fb_cnt = '0;
        state_next.fb_out = ~state_reg.fb_out;
      end
      else
      begin
        state_next.fb_cnt = state_reg.fb_cnt + CNT_W'(9'h001);
      end
      if (state_reg.od_cnt >= od_half - CNT_W'(9'h001))
      begin
        state_next.od_cnt = '0;
        state_next.synth  = ~state_reg.synth;
      end
      else
      begin
        state_next.od_cnt = state_reg.od_cnt + CNT_W'(9'h001);
      end
    end

    // Output stage: true low and complement high under reset.
    state_next.out_true = hold_reset ? 1'b0 : state_next.synth;   // see [R1] see [R2]
    state_next.out_comp = hold_reset ? 1'b1 : ~state_next.synth;

    // Diagnostic output; forced low in parallel mode and under reset.
    if (hold_reset || !pl_n)
    begin
      state_next.diag = 1'b0;                                  // see [R4] see [R10]
    end
    else
    begin
      case (state_reg.cfg.diag_sel)                            // see [R17]
        DIAG_LOW:   state_next.diag = 1'b0;
        DIAG_SDATA: state_next.diag = state_reg.pins_sync.serial_data;
        DIAG_FB:    state_next.diag = state_reg.fb_out;
        DIAG_SYNTH: state_next.diag = state_reg.synth;
        default:    state_next.diag = 1'b0;
      endcase
    end

    // Register port: control write and one-cycle-late read data.
    if (wr_en_in && addr_in == CONTROL_OFS)
    begin
      state_next.soft_reset = wr_data_in[CTL_RST_BIT];
    end
    state_next.rd_data = '0;
    if (rd_en_in)
    begin
      if (addr_in == STATUS_OFS)
      begin
        state_next.rd_data[ST_FB_LSB +: FB_W] = state_reg.cfg.feedback_div;
        state_next.rd_data[ST_OD_LSB +: OD_W] = state_reg.cfg.out_div;
        state_next.rd_data[ST_DS_LSB +: DS_W] = state_reg.cfg.diag_sel;
        state_next.rd_data[ST_PAR_BIT]        = ~pl_n;
        state_next.rd_data[ST_RST_BIT]        = hold_reset;
        state_next.rd_data[ST_BYP_BIT]        = ~state_reg.pins_sync.pll_bypass_select;
        state_next.rd_data[ST_REF_BIT]        = state_reg.pins_sync.ref_source_select;
      end
      else if (addr_in == CONTROL_OFS)
      begin
        state_next.rd_data[CTL_RST_BIT] = state_reg.soft_reset;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // State register.

  // Reset values are constants only; the complementary outputs idle high.
  always_ff @(posedge clk_sys_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg          <= '0;
      state_reg.cfg      <= {DS_RESET, OD_RESET, FB_RESET};
      state_reg.shift    <= FRAME_RESET;
      state_reg.out_comp <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register.

  // Both synthesizer pairs carry the same divided signal.
  assign synth_out_a_out      = state_reg.out_true;
  assign synth_out_a_comp_out = state_reg.out_comp;
  assign synth_out_b_out      = state_reg.out_true;
  assign synth_out_b_comp_out = state_reg.out_comp;
  assign diag_out             = state_reg.diag;
  assign rd_data_out          = state_reg.rd_data;

endmodule

// ---- sim/sdc_config_port_monitor.sv ----
`timescale 1ns/1ps

module sdc_cfg_monitor
(
  input wire logic                       clk_sys_in,
  input wire logic                       rst_b_in,
  input wire sdc_pkg::sdc_pins_t         pins_in,
  input wire logic [sdc_pkg::ADDR_W-1:0] addr_in,
  input wire logic                       rd_en_in,
  input wire logic [sdc_pkg::DATA_W-1:0] rd_data_out,
  input wire logic                       synth_out_a_out,
  input wire logic                       synth_out_a_comp_out,
  input wire logic                       synth_out_b_out,
  input wire logic                       diag_out
);
  import sdc_pkg::*;

  wire logic st_rd;

  // A status read is taken here so the properties stay short.
  assign st_rd = rd_en_in && (addr_in == STATUS_OFS);

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  ////////////////////////////////////////////////////////////////////////////////
  // Pins pass two sync flops, so six samples cover the whole latency.
  chk_comp_pair: assert property (synth_out_a_comp_out == !synth_out_a_out)
    else $error("complementary output wrong");
  chk_out_twin: assert property (synth_out_b_out == synth_out_a_out)
    else $error("synth outputs differ");
  chk_mr_low: assert property (pins_in.master_reset [*6] |-> !synth_out_a_out)
    else $error("output not low under master reset");
  chk_mr_diag: assert property (pins_in.master_reset [*6] |-> !diag_out)
    else $error("diag not low under master reset");
  chk_par_diag: assert property (!pins_in.parallel_latch_n [*6] |-> !diag_out)
    else $error("diag not low in parallel mode");
  chk_ref_sel: assert property (($stable(pins_in.ref_source_select) [*6]) ##0 st_rd
    |=> rd_data_out[ST_REF_BIT] == $past(pins_in.ref_source_select))
    else $error("reference select status wrong");
  chk_mr_stat: assert property (pins_in.master_reset [*6] ##0 st_rd
    |=> rd_data_out[ST_RST_BIT])
    else $error("reset status not set");
  chk_par_pass: assert property ((!pins_in.master_reset && !pins_in.parallel_latch_n
    && $stable(pins_in.feedback_div) && $stable(pins_in.out_div)) [*6] ##0 st_rd
    |=> rd_data_out[11:0] == {$past(pins_in.out_div), $past(pins_in.feedback_div)})
    else $error("parallel pins not passed");
endmodule

bind sdc_config_port sdc_cfg_monitor i_mon (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
  .pins_in(pins_in), .addr_in(addr_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
  .synth_out_a_out(synth_out_a_out), .synth_out_a_comp_out(synth_out_a_comp_out),
  .synth_out_b_out(synth_out_b_out), .diag_out(diag_out));

// ---- sim/sdc_host_model.sv ----
`timescale 1ns/1ps

module sdc_host_model
(
  input  wire logic          clk_in,
  output sdc_pkg::sdc_pins_t pins_out
);
  import sdc_pkg::*;

  // Straps start in serial mode with crystal and PLL picked.
  initial
  begin
    pins_out = '0;
    pins_out.parallel_latch_n = 1'b1;
    pins_out.ref_source_select = 1'b1;
    pins_out.pll_bypass_select = 1'b1;
  end

  // Each level stands four system clocks, one more than the port needs.
  task automatic put(input sdc_pins_t v);
    @(posedge clk_in);
    pins_out <= v;
    repeat (3) @(posedge clk_in);
  endtask

  task automatic par(input logic ln, input logic [FB_W-1:0] fb, input logic [OD_W-1:0] od);
    sdc_pins_t v;
    v = pins_out;
    v.parallel_latch_n = ln;
    v.feedback_div = fb;
    v.out_div = od;
    put(v);
  endtask

  // Mode 0 shifts only, 1 shifts then strobes, 2 shifts with the strobe held high.
  task automatic frame(input logic [FRAME_W-1:0] f, input logic [1:0] mode);
    sdc_pins_t v;
    v = pins_out;
    v.parallel_latch_n = 1'b1;
    v.serial_clock = 1'b0;
    v.serial_load = (mode == 2'd2);
    put(v);
    for (int i = FRAME_W - 1; i >= 0; i--)
    begin
      v.serial_data = f[i];
      v.serial_clock = 1'b0;
      put(v);
      v.serial_clock = 1'b1;
      put(v);
    end
    v.serial_clock = 1'b0;
    put(v);
    v.serial_load = (mode == 2'd1);
    put(v);
    v.serial_load = 1'b0;
    put(v);
  endtask
endmodule

// ---- sim/sdc_config_port_bench.sv ----
`timescale 1ns/1ps

`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin error_cnt++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, got); end end

module sdc_config_port_bench;
  import sdc_pkg::*;

  logic              clk_sys_in = 1'b0;
  logic              rst_b_in = 1'b0;
  logic [ADDR_W-1:0] addr_in = '0;
  logic [DATA_W-1:0] wr_data_in = '0;
  logic              wr_en_in = 1'b0;
  logic              rd_en_in = 1'b0;
  logic [DATA_W-1:0] rd_data_out;
  logic [3:0]        outs;
  logic              diag;
  logic              prev;
  sdc_pins_t         pins;
  sdc_pins_t         pv;
  logic [31:0]       seed = 32'h6ef4fe82;
  logic [31:0]       d;
  logic [FB_W-1:0]   fb;
  logic [13:0]       f;
  int                toggles;
  int                error_cnt = 0;
  int                samples_checked = 0;

  always #20 clk_sys_in = ~clk_sys_in;

  sdc_host_model i_host (.clk_in(clk_sys_in), .pins_out(pins));

  sdc_config_port i_dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .pins_in(pins),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .synth_out_a_out(outs[3]), .synth_out_a_comp_out(outs[2]),
    .synth_out_b_out(outs[1]), .synth_out_b_comp_out(outs[0]), .diag_out(diag));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Strobes last one cycle; read data is taken in the cycle after the strobe.
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_en_in <= 1'b0;
    #1 d = rd_data_out;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk_sys_in);
    addr_in <= a;
    wr_data_in <= v;
    wr_en_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_en_in <= 1'b0;
  endtask

  // Lets the pin sync and output register land before outputs are looked at.
  task automatic wt();
    repeat (2) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic summarize();
    $display("Checked %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, random loads through both paths, then corner cases.
  initial
  begin
    repeat (4) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    rd(STATUS_OFS);
    `CHK("cfg_reset", 14'h0000, d[13:0]);
    rd(8'h08);
    `CHK("unmapped", 32'h0, d);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      fb = 9'd100 + {1'b0, seed[7:0]} % 9'd251;
      f = {seed[13:9], fb};
      i_host.par(1'b0, fb, seed[11:9]);
      rd(STATUS_OFS);
      `CHK("par_pass", {seed[11:9], fb}, d[11:0]);
      `CHK("par_diag", 1'b0, diag);
      i_host.par(1'b1, fb, seed[11:9]);
      i_host.par(1'b1, ~fb, ~seed[11:9]);
      rd(STATUS_OFS);
      `CHK("par_hold", {seed[11:9], fb}, d[11:0]);
      i_host.frame(f, 2'd1);
      rd(STATUS_OFS);
      `CHK("ser_load", f, d[13:0]);
      i_host.frame(~f, 2'd0);
      rd(STATUS_OFS);
      `CHK("ser_hold", f, d[13:0]);
      i_host.frame({~f[13:12], f[11:0]}, 2'd2);
      rd(STATUS_OFS);
      `CHK("ser_thru", {~f[13:12], f[11:0]}, d[13:0]);
    end
    for (int s = 0; s < 4; s++)
    begin
      i_host.frame({2'(s), 12'h064}, 2'd1);
      for (int b = 0; b < 2; b++)
      begin
        pv = pins;
        pv.serial_data = 1'(b);
        i_host.put(pv);
        wt();
        if (s < 2) `CHK("diag_sel", 1'(b * s), diag);
      end
      // Divider-driven selections are free running, so they are checked for movement.
      if (s >= 2)
      begin
        toggles = 0;
        prev = diag;
        repeat (300)
        begin
          @(posedge clk_sys_in);
          #1;
          toggles += int'(diag != prev);
          prev = diag;
        end
        `CHK("diag_run", 1'b1, toggles > 0);
      end
    end
    i_host.frame(14'h0064, 2'd1);
    pv = pins;
    pv.master_reset = 1'b1;
    i_host.put(pv);
    wt();
    `CHK("mr_outs", 4'b0101, outs);
    i_host.par(1'b0, 9'd200, 3'h3);
    i_host.par(1'b1, 9'd200, 3'h3);
    rd(STATUS_OFS);
    `CHK("mr_keep", 16'h8064, d[15:0]);
    pv = pins;
    pv.master_reset = 1'b0;
    i_host.put(pv);
    toggles = 0;
    prev = outs[3];
    repeat (300)
    begin
      @(posedge clk_sys_in);
      #1;
      toggles += int'(outs[3] != prev);
      prev = outs[3];
    end
    `CHK("mr_run", 1'b1, toggles > 0);
    wr(CONTROL_OFS, 32'h1);
    rd(CONTROL_OFS);
    `CHK("ctl_rw", 1'b1, d[CTL_RST_BIT]);
    rd(STATUS_OFS);
    `CHK("soft_rst", 1'b1, d[ST_RST_BIT]);
    wr(CONTROL_OFS, 32'h0);
    for (int r = 0; r < 2; r++)
    begin
      pv = pins;
      pv.ref_source_select = 1'(r);
      i_host.put(pv);
      rd(STATUS_OFS);
      `CHK("ref_sel", 1'(r), d[ST_REF_BIT]);
    end
    summarize();
  end

  // Watchdog sized well above the few thousand cycles the sequence needs.
  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    error_cnt++;
    summarize();
  end
endmodule
